// ### rtl/ee_host.sv
// Bus master end: byte write, page write and random/sequential read.
// Assumes a single target on the link and no clock stretching.
`timescale 1ns/1ps
`include "ee_params.svh"
module ee_host
   import ee_pkg::*;
(
   input  wire logic        clk_in,
   input  wire logic        nrst_in,
   input  wire logic        cmd_valid_in,
   input  wire logic        cmd_read_in,
   input  wire logic [2:0]  cmd_chip_in,
   input  wire logic [15:0] cmd_addr_in,
   input  wire logic [5:0]  cmd_len_in,
   input  wire logic [7:0]  wdata_in,
   output logic             cmd_ready_out,
   output logic             wdata_take_out,
   output logic [7:0]       rdata_out,
   output logic             rdata_valid_out,
   output logic             done_out,
   output logic             nack_out,
   ee_link_if.host          link
);

   localparam logic [4:0] QTR_M1 = 5'(`EE_SCL_QTR_CYC - 1);

   logic [1:0]  sda_s_reg;
   logic [4:0]  q_reg;
   logic [1:0]  ph_reg;
   ee_hst_t     hs_reg;
   ee_seq_t     seq_reg;
   logic [3:0]  bit_reg;
   logic [7:0]  tx_reg;
   logic [8:0]  rx_reg;
   logic [5:0]  len_reg;
   logic        rd_reg;
   logic [2:0]  chip_reg;
   logic [15:0] addr_reg;
   logic        retry_reg;
   logic        scl_oe_reg;
   logic        sda_oe_reg;
   logic        ready_reg;
   logic        take_reg;
   logic [7:0]  rdata_reg;
   logic        rvalid_reg;
   logic        done_reg;
   logic        nack_reg;
   logic        tick;
   logic [7:0]  dev_byte;

   // Data line passes two flip-flops
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         sda_s_reg <= 2'h_3;
      end else begin
         sda_s_reg <= {sda_s_reg[0], link.sda_line};
      end
   end

   // Quarter-bit divider for the generated serial clock
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         q_reg <= 5'h_00;
      end else if (hs_reg == HS_IDLE || tick) begin
         q_reg <= 5'h_00;
      end else begin
         q_reg <= q_reg + 5'h_01;
      end
   end

   assign tick     = (q_reg == QTR_M1);
   assign dev_byte = {`EE_DEV_TYPE, chip_reg, seq_reg == SQ_DEVR}; // RULE15

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         ph_reg     <= 2'h_0;
         hs_reg     <= HS_IDLE;
         seq_reg    <= SQ_DEVW;
         bit_reg    <= 4'h_0;
         tx_reg     <= 8'h_ff;
         rx_reg     <= 9'h_000;
         len_reg    <= 6'h_00;
         rd_reg     <= 1'b0;
         chip_reg   <= 3'h_0;
         addr_reg   <= 16'h_0000;
         retry_reg  <= 1'b0;
         scl_oe_reg <= 1'b0;
         sda_oe_reg <= 1'b0;
         ready_reg  <= 1'b1;
         take_reg   <= 1'b0;
         rdata_reg  <= 8'h_00;
         rvalid_reg <= 1'b0;
         done_reg   <= 1'b0;
         nack_reg   <= 1'b0;
      end else begin
         take_reg   <= 1'b0;
         rvalid_reg <= 1'b0;
         done_reg   <= 1'b0;
         nack_reg   <= 1'b0;
         if (hs_reg == HS_IDLE) begin
            if (cmd_valid_in && ready_reg) begin
               ready_reg <= 1'b0;
               rd_reg    <= cmd_read_in;
               chip_reg  <= cmd_chip_in;
               addr_reg  <= cmd_addr_in;
               len_reg   <= cmd_len_in;
               seq_reg   <= SQ_DEVW; // RULE14
               ph_reg    <= 2'h_0;
               hs_reg    <= HS_START;
            end
         end else if (tick) begin
            ph_reg <= ph_reg + 2'h_1;
            case (hs_reg)
               HS_START: begin
                  case (ph_reg)
                     2'h_0: sda_oe_reg <= 1'b0;
                     2'h_1: scl_oe_reg <= 1'b0;
                     2'h_2: sda_oe_reg <= 1'b1;
                     default: begin
                        scl_oe_reg <= 1'b1;
                        tx_reg     <= dev_byte; // RULE1
                        bit_reg    <= 4'h_0;
                        hs_reg     <= HS_BIT;
                     end
                  endcase
               end
               HS_BIT: begin
                  case (ph_reg)
                     2'h_0: begin
                        if (bit_reg == 4'h_8) begin
                           sda_oe_reg <= (seq_reg == SQ_RDAT) && (len_reg != 6'h_01); // RULE16 RULE13
                        end else begin
                           sda_oe_reg <= ~tx_reg[7];
                        end
                     end
                     2'h_1: scl_oe_reg <= 1'b0;
                     2'h_2: rx_reg <= {rx_reg[7:0], sda_s_reg[1]};
                     default: begin
                        scl_oe_reg <= 1'b1;
                        tx_reg     <= {tx_reg[6:0], 1'b1};
                        bit_reg    <= bit_reg + 4'h_1;
                        if (bit_reg == 4'h_8) begin
                           bit_reg <= 4'h_0;
                           if (seq_reg != SQ_RDAT && rx_reg[0]) begin
                              if (seq_reg == SQ_DEVW || seq_reg == SQ_DEVR) begin
                                 retry_reg <= 1'b1; // RULE10
                              end else begin
                                 nack_reg <= 1'b1;
                              end
                              hs_reg <= HS_STOP;
                           end else begin
                              case (seq_reg)
                                 SQ_DEVW: begin
                                    seq_reg <= SQ_AHI;
                                    tx_reg  <= addr_reg[15:8]; // RULE2
                                 end
                                 SQ_AHI: begin
                                    seq_reg <= SQ_ALO;
                                    tx_reg  <= addr_reg[7:0];
                                 end
                                 SQ_ALO: begin
                                    if (rd_reg) begin
                                       seq_reg <= SQ_DEVR; // RULE14
                                       hs_reg  <= HS_START;
                                    end else begin
                                       seq_reg  <= SQ_WDAT;
                                       tx_reg   <= wdata_in;
                                       take_reg <= 1'b1;
                                    end
                                 end
                                 SQ_WDAT: begin
                                    len_reg <= len_reg - 6'h_01;
                                    if (len_reg == 6'h_01) begin
                                       hs_reg <= HS_STOP; // RULE4 RULE7
                                    end else begin
                                       tx_reg   <= wdata_in;
                                       take_reg <= 1'b1;
                                    end
                                 end
                                 SQ_DEVR: begin
                                    seq_reg <= SQ_RDAT;
                                    tx_reg  <= 8'h_ff;
                                 end
                                 default: begin
                                    rdata_reg  <= rx_reg[8:1];
                                    rvalid_reg <= 1'b1;
                                    tx_reg     <= 8'h_ff;
                                    len_reg    <= len_reg - 6'h_01;
                                    if (len_reg == 6'h_01) begin
                                       hs_reg <= HS_STOP; // RULE13
                                    end
                                 end
                              endcase
                           end
                        end
                     end
                  endcase
               end
               HS_STOP: begin
                  case (ph_reg)
                     2'h_0: sda_oe_reg <= 1'b1;
                     2'h_1: scl_oe_reg <= 1'b0;
                     2'h_2: sda_oe_reg <= 1'b0;
                     default: begin
                        if (retry_reg) begin
                           retry_reg <= 1'b0;
                           seq_reg   <= SQ_DEVW; // RULE10
                           hs_reg    <= HS_START;
                        end else begin
                           hs_reg    <= HS_IDLE;
                           ready_reg <= 1'b1;
                           done_reg  <= 1'b1;
                        end
                     end
                  endcase
               end
               default: hs_reg <= HS_IDLE;
            endcase
         end
      end
   end

   assign link.scl_h_oe  = scl_oe_reg;
   assign link.scl_h_out = 1'b0;
   assign link.sda_h_oe  = sda_oe_reg;
   assign link.sda_h_out = 1'b0;
   assign cmd_ready_out   = ready_reg;
   assign wdata_take_out  = take_reg;
   assign rdata_out       = rdata_reg;
   assign rdata_valid_out = rvalid_reg;
   assign done_out        = done_reg;
   assign nack_out        = nack_reg;

endmodule

// ### rtl/ee_params.svh
// Timing, layout and code constants shared by both ends of the EEPROM link.
// Assumes a 40 MHz system clock on both ends.
// Function
// [RULE1] Write: START, select with write, two address bytes
// [RULE2] Address is two bytes, upper unused bits ignored
// [RULE3] Write-protect high until address end blocks writes
// [RULE4] Byte write: one acked data byte, then STOP
// [RULE5] Page write takes one to 32 bytes
// [RULE6] Write increments only low five address bits
// [RULE7] Master avoids overrunning the current row; ee_host sends all cmd_len_in bytes without a row check
// [RULE8] Only STOP right after acknowledge starts programming
// [RULE9] Programming ignores bus until it completes
// [RULE10] Master polls select; device acks when ready
// [RULE11] Memory starts as all 0xFF
// [RULE12] Current read: ack, output byte, increment counter
// [RULE13] Single read ends with no-ack then STOP
// [RULE14] Random read: dummy write, restart, read select
// [RULE15] Both select bytes share upper seven bits
// [RULE16] Sequential read continues on master acknowledge
// [RULE17] Read counter wraps over whole memory
// [RULE18] Read no-ack in ninth bit returns standby
// [RULE19] Select acked only on type and chip match
`ifndef EE_PARAMS_SVH
`define EE_PARAMS_SVH

`define EE_DEV_TYPE      4'h_a
`define EE_ADDR_W        13
`define EE_MEM_BYTES     8192
`define EE_ROW_W         8
`define EE_COL_W         5
`define EE_PAGE_BYTES    32
`define EE_CLK_HZ        40000000
`define EE_CLK_PERIOD_NS 25
`define EE_PROG_TIME_MS  10
`define EE_PROG_CYC      ((`EE_PROG_TIME_MS * `EE_CLK_HZ) / 1000)
`define EE_SCL_PERIOD_NS 2500
`define EE_SCL_QTR_CYC   ((`EE_SCL_PERIOD_NS + 4 * `EE_CLK_PERIOD_NS - 1) / (4 * `EE_CLK_PERIOD_NS))

`endif

// ### rtl/ee_pkg.sv
// State types for the EEPROM target and its bus master.
// Assumes nothing beyond a SystemVerilog compiler.
package ee_pkg;

   typedef enum logic [2:0] {
      DS_IDLE,
      DS_DEV,
      DS_AHI,
      DS_ALO,
      DS_WDAT,
      DS_RDAT
   } ee_dst_t;

   typedef enum logic [1:0] {
      HS_IDLE,
      HS_START,
      HS_BIT,
      HS_STOP
   } ee_hst_t;

   typedef enum logic [2:0] {
      SQ_DEVW,
      SQ_AHI,
      SQ_ALO,
      SQ_WDAT,
      SQ_DEVR,
      SQ_RDAT
   } ee_seq_t;

endpackage

// ### rtl/ee_link_if.sv
// Two-wire link between the bus master and the EEPROM target.
// Open-drain: a line is low while any enabled driver puts out zero.
`timescale 1ns/1ps
interface ee_link_if;
   logic scl_h_out;
   logic scl_h_oe;
   logic sda_h_out;
   logic sda_h_oe;
   logic sda_d_out;
   logic sda_d_oe;
   logic scl_line;
   logic sda_line;

   assign scl_line = ~(scl_h_oe & ~scl_h_out);
   assign sda_line = ~((sda_h_oe & ~sda_h_out) | (sda_d_oe & ~sda_d_out));

   modport dev (
      input  scl_line,
      input  sda_line,
      output sda_d_out,
      output sda_d_oe
   );

   modport host (
      input  sda_line,
      output scl_h_out,
      output scl_h_oe,
      output sda_h_out,
      output sda_h_oe
   );
endinterface

// ### rtl/ee_dev.sv
// EEPROM target end: select decode, address load, page write, reads.
// Assumes the link lines and straps are asynchronous to clk_in.
`timescale 1ns/1ps
`include "ee_params.svh"
module ee_dev
   import ee_pkg::*;
#(
   parameter int PROG_CYC = `EE_PROG_CYC
) (
   input  wire logic       clk_in,
   input  wire logic       nrst_in,
   input  wire logic       write_protect_pin_in,
   input  wire logic [2:0] chip_select_inputs_in,
   output logic            busy_out,
   ee_link_if.dev          link
);

   localparam int CNT_W = $clog2(PROG_CYC + 1);

   logic [5:0]               s1_reg;
   logic [5:0]               s2_reg;
   logic [1:0]               prev_reg;
   ee_dst_t                  st_reg;
   ee_dst_t                  nxt_reg;
   logic [3:0]               bit_reg;
   logic [7:0]               shf_reg;
   logic [7:0]               tx_reg;
   logic [`EE_ADDR_W-1:0]    addr_reg;
   logic [4:0]               ahi_reg;
   logic [`EE_ROW_W-1:0]     row_reg;
   logic [`EE_PAGE_BYTES-1:0] pg_vld_reg;
   logic                     ack_reg;
   logic                     oe_reg;
   logic                     wp_reg;
   logic                     busy_reg;
   logic [CNT_W-1:0]         cnt_reg;
   logic [7:0]               pg_buf [0:`EE_PAGE_BYTES-1];
   logic [7:0]               mem_reg [0:`EE_MEM_BYTES-1] = '{default: 8'h_ff}; // RULE11

   logic                     scl;
   logic                     sda;
   logic                     wp;
   logic [2:0]               cs;
   logic                     scl_rise;
   logic                     scl_fall;
   logic                     start;
   logic                     stop;
   logic                     prog_done;
   logic [7:0]               sh_next;

   // Pins pass two flip-flops before use
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         s1_reg   <= 6'h_3f;
         s2_reg   <= 6'h_3f;
         prev_reg <= 2'h_3;
      end else begin
         s1_reg   <= {chip_select_inputs_in, write_protect_pin_in, link.sda_line, link.scl_line};
         s2_reg   <= s1_reg;
         prev_reg <= s2_reg[1:0];
      end
   end

   assign scl      = s2_reg[0];
   assign sda      = s2_reg[1];
   assign wp       = s2_reg[2];
   assign cs       = s2_reg[5:3];
   assign scl_rise = scl & ~prev_reg[0];
   assign scl_fall = ~scl & prev_reg[0];
   assign start    = scl & prev_reg[0] & prev_reg[1] & ~sda;
   assign stop     = scl & prev_reg[0] & ~prev_reg[1] & sda;
   assign sh_next  = {shf_reg[6:0], sda};

   // Self-timed program cycle length
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         cnt_reg <= '0;
      end else if (busy_reg && !prog_done) begin
         cnt_reg <= cnt_reg + CNT_W'(1);
      end else begin
         cnt_reg <= '0;
      end
   end

   assign prog_done = busy_reg && (cnt_reg == CNT_W'(PROG_CYC - 1));

   // Commit latched page at end of program cycle
   always_ff @(posedge clk_in) begin
      if (prog_done) begin
         for (int i = 0; i < `EE_PAGE_BYTES; i++) begin
            if (pg_vld_reg[i]) begin
               mem_reg[{row_reg, 5'(i)}] <= pg_buf[i];
            end
         end
      end
   end

   // Bus protocol engine
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         st_reg     <= DS_IDLE;
         nxt_reg    <= DS_IDLE;
         bit_reg    <= 4'h_0;
         shf_reg    <= 8'h_00;
         tx_reg     <= 8'h_ff;
         addr_reg   <= '0;
         ahi_reg    <= 5'h_00;
         row_reg    <= '0;
         pg_vld_reg <= '0;
         ack_reg    <= 1'b0;
         oe_reg     <= 1'b0;
         wp_reg     <= 1'b0;
         busy_reg   <= 1'b0;
      end else begin
         if (prog_done) begin
            busy_reg <= 1'b0;
         end
         if (start) begin
            st_reg  <= DS_DEV;
            bit_reg <= 4'h_0;
            ack_reg <= 1'b0;
            oe_reg  <= 1'b0;
            wp_reg  <= wp; // RULE3
         end else if (stop) begin
            if (st_reg == DS_WDAT && bit_reg == 4'h_1 && pg_vld_reg != '0 && !busy_reg) begin
               busy_reg <= 1'b1; // RULE8
            end
            st_reg  <= DS_IDLE;
            ack_reg <= 1'b0;
            oe_reg  <= 1'b0;
         end else begin
            if (wp && (st_reg == DS_DEV || st_reg == DS_AHI || st_reg == DS_ALO)) begin
               wp_reg <= 1'b1; // RULE3
            end
            if (scl_rise && st_reg != DS_IDLE) begin
               shf_reg <= sh_next;
               if (st_reg == DS_RDAT && bit_reg != 4'h_8) begin
                  tx_reg <= {tx_reg[6:0], 1'b1};
               end
               if (bit_reg == 4'h_8) begin
                  bit_reg <= 4'h_0;
                  ack_reg <= 1'b0;
                  if (st_reg == DS_RDAT) begin
                     addr_reg <= addr_reg + `EE_ADDR_W'(1); // RULE17
                     tx_reg   <= mem_reg[addr_reg + `EE_ADDR_W'(1)]; // RULE16
                     if (sda) begin
                        st_reg <= DS_IDLE; // RULE18
                     end
                  end else begin
                     st_reg <= nxt_reg;
                  end
               end else begin
                  bit_reg <= bit_reg + 4'h_1;
               end
               if (bit_reg == 4'h_7) begin
                  case (st_reg)
                     DS_DEV: begin
                        if (sh_next[7:4] == `EE_DEV_TYPE && sh_next[3:1] == cs
                            && !busy_reg) begin // RULE19 RULE10 RULE9
                           ack_reg <= 1'b1;
                           if (sh_next[0]) begin
                              nxt_reg <= DS_RDAT; // RULE12
                              tx_reg  <= mem_reg[addr_reg];
                           end else begin
                              nxt_reg <= DS_AHI; // RULE1
                           end
                        end else begin
                           nxt_reg <= DS_IDLE;
                        end
                     end
                     DS_AHI: begin
                        ahi_reg <= sh_next[4:0]; // RULE2
                        ack_reg <= 1'b1;
                        nxt_reg <= DS_ALO;
                     end
                     DS_ALO: begin
                        addr_reg   <= {ahi_reg, sh_next}; // RULE2
                        row_reg    <= {ahi_reg, sh_next[7:5]}; // RULE5
                        pg_vld_reg <= '0;
                        ack_reg    <= 1'b1;
                        nxt_reg    <= DS_WDAT;
                     end
                     DS_WDAT: begin
                        nxt_reg <= DS_WDAT;
                        if (!wp_reg) begin
                           pg_buf[addr_reg[4:0]]     <= sh_next; // RULE5 RULE4
                           pg_vld_reg[addr_reg[4:0]] <= 1'b1;
                           ack_reg                   <= 1'b1;
                           addr_reg[4:0]             <= addr_reg[4:0] + 5'h_01; // RULE6
                        end
                     end
                     default: begin
                        nxt_reg <= st_reg;
                     end
                  endcase
               end
            end
            if (scl_fall) begin
               if (bit_reg == 4'h_8) begin
                  oe_reg <= ack_reg;
               end else if (st_reg == DS_RDAT) begin
                  oe_reg <= ~tx_reg[7];
               end else begin
                  oe_reg <= 1'b0;
               end
            end
         end
      end
   end

   assign link.sda_d_oe  = oe_reg;
   assign link.sda_d_out = 1'b0;
   assign busy_out       = busy_reg;

endmodule

// ### verification/ee_link_sva.sv
// Link checker: framing, acknowledge timing and program-cycle behaviour.
// Assumes the resolved link lines, the data drivers' enables and the target's busy flag.
`timescale 1ns/1ps
module ee_link_sva #(
   parameter int PROG_CYC = 200
) (
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic scl_line,
   input wire logic sda_line,
   input wire logic scl_h_out,
   input wire logic sda_h_out,
   input wire logic sda_h_oe,
   input wire logic sda_d_out,
   input wire logic sda_d_oe,
   input wire logic busy_out
);
   logic [31:0] bcnt_reg;
   logic        frame_reg;
   logic        scl_q_reg;
   logic        sda_q_reg;

   default clocking @(posedge clk_in); endclocking
   default disable iff (!nrst_in);

   // Length of the running program cycle
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         bcnt_reg <= '0;
      end else begin
         bcnt_reg <= busy_out ? bcnt_reg + 32'h0000_0001 : '0;
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         scl_q_reg <= 1'b1;
         sda_q_reg <= 1'b1;
      end else begin
         scl_q_reg <= scl_line;
         sda_q_reg <= sda_line;
      end
   end

   // High between START and STOP
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         frame_reg <= 1'b0;
      end else if (scl_line && scl_q_reg && sda_q_reg && !sda_line) begin
         frame_reg <= 1'b1;
      end else if (scl_line && scl_q_reg && !sda_q_reg && sda_line) begin
         frame_reg <= 1'b0;
      end
   end

   a_open_drain_low: assert property (!scl_h_out && !sda_h_out && !sda_d_out)
      else $error("link driver data not held low");
   a_scl_high_width: assert property ($rose(scl_line) |-> scl_line [*8])
      else $error("clock high phase too short");
   a_dev_oe_scl_low: assert property ($changed(sda_d_oe) |-> !scl_line)
      else $error("target changed data while clock high");
   a_dev_ack_frame: assert property ($rose(sda_d_oe) |-> frame_reg)
      else $error("target drove data outside a frame");
   a_busy_after_stop: assert property ($rose(busy_out) |-> !frame_reg && scl_line && sda_line)
      else $error("program cycle began without a stop");
   a_busy_no_ack: assert property (busy_out |-> !sda_d_oe)
      else $error("target answered while programming");
   a_busy_length: assert property ($fell(busy_out) |-> bcnt_reg == PROG_CYC)
      else $error("program cycle length wrong");
   a_no_clash_high: assert property (scl_line |-> !(sda_h_oe && sda_d_oe))
      else $error("both ends drive data while clock high");

   c_program: cover property ($rose(busy_out));
   c_dev_ack: cover property ($rose(sda_d_oe));
   c_host_ack: cover property (scl_line && sda_h_oe && !frame_reg == 1'b0);
endmodule

// ### verification/i2c_eeprom_write_read_engine_tb_top.sv
// Bench joining bus master and target over the link; drives the command port.
// Assumes a shortened program cycle and the target strapped to chip code 2.
`timescale 1ns/1ps
module i2c_eeprom_write_read_engine_tb_top;
   // Long enough that the read after a write must poll
   localparam int PROG  = 2500;
   localparam int LIMIT = 90000;
   logic       clk_in    = 1'b0;
   logic       nrst_in   = 1'b0;
   logic       wprot     = 1'b0;
   logic [2:0] straps    = 3'b010;
   logic       cmd_valid = 1'b0;
   logic       cmd_read  = 1'b0;
   logic [2:0] cmd_chip  = 3'b000;
   logic [15:0] cmd_addr = 16'h0000;
   logic [5:0] cmd_len   = 6'h00;
   logic [7:0] wdata     = 8'h00;
   logic       ready, take, rvalid, done, nack, busy;
   logic [7:0] rdata;
   logic [7:0] wb [0:63];
   logic [7:0] eb [0:63];
   logic [7:0] got [$];
   logic       nk, bz, ack_seen;
   int         errors = 0;
   int         n_compared = 0;
   int         cyc = 0;

   ee_link_if link_if ();
   ee_dev #(.PROG_CYC(PROG)) ee_dev_inst (
      .clk_in(clk_in), .nrst_in(nrst_in), .write_protect_pin_in(wprot),
      .chip_select_inputs_in(straps), .busy_out(busy), .link(link_if));
   ee_host ee_host_inst (
      .clk_in(clk_in), .nrst_in(nrst_in), .cmd_valid_in(cmd_valid), .cmd_read_in(cmd_read),
      .cmd_chip_in(cmd_chip), .cmd_addr_in(cmd_addr), .cmd_len_in(cmd_len), .wdata_in(wdata),
      .cmd_ready_out(ready), .wdata_take_out(take), .rdata_out(rdata),
      .rdata_valid_out(rvalid), .done_out(done), .nack_out(nack), .link(link_if));
   ee_link_sva #(.PROG_CYC(PROG)) ee_link_sva_inst (
      .clk_in(clk_in), .nrst_in(nrst_in), .scl_line(link_if.scl_line),
      .sda_line(link_if.sda_line), .scl_h_out(link_if.scl_h_out),
      .sda_h_out(link_if.sda_h_out), .sda_h_oe(link_if.sda_h_oe),
      .sda_d_out(link_if.sda_d_out), .sda_d_oe(link_if.sda_d_oe), .busy_out(busy));

   always #12.5 clk_in = ~clk_in;

   always @(posedge clk_in) begin
      if (link_if.sda_d_oe === 1'b1) ack_seen <= 1'b1;
   end

   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         errors = errors + 1;
         conclude();
      end
   end

   task automatic conclude();
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Held until the edge that finds the master ready
   task automatic issue(input logic rd, input logic [2:0] chip, input logic [15:0] addr,
                        input logic [5:0] len);
      cmd_read <= rd;
      cmd_chip <= chip;
      cmd_addr <= addr;
      cmd_len <= len;
      wdata <= wb[0];
      cmd_valid <= 1'b1;
      @(posedge clk_in);
      while (ready !== 1'b1) @(posedge clk_in);
      cmd_valid <= 1'b0;
   endtask

   task automatic run(input logic rd, input logic [15:0] addr, input logic [5:0] len);
      int k;
      bit dn;
      k = 0;
      dn = 0;
      nk = 1'b0;
      bz = 1'b0;
      got.delete();
      issue(rd, 3'b010, addr, len);
      while (!dn) begin
         @(posedge clk_in);
         if (take === 1'b1) begin
            k++;
            wdata <= wb[k];
         end
         if (rvalid === 1'b1) got.push_back(rdata);
         if (nack === 1'b1) nk = 1'b1;
         dn = (done === 1'b1);
      end
      // Program cycle starts a few clocks after the stop
      repeat (40) begin
         @(posedge clk_in);
         if (busy === 1'b1) bz = 1'b1;
      end
   endtask

   task automatic rd_chk(input logic [15:0] addr, input int n);
      run(1'b1, addr, n[5:0]);
      check("read count", 16'(got.size()), 16'(n));
      for (int i = 0; i < n; i++) check("read byte", {8'h00, got[i]}, {8'h00, eb[i]});
   endtask

   initial begin
      repeat (16) @(posedge clk_in);
      nrst_in <= 1'b1;
      @(posedge clk_in);
      eb[0] = 8'hff;
      eb[1] = 8'hff;
      rd_chk(16'h0010, 2);
      wb[0] = 8'h3c;
      run(1'b0, 16'he000, 6'h01);
      check("write busy", {15'h0000, bz}, 16'h0001);
      check("poll busy", {15'h0000, busy}, 16'h0001);
      eb[1] = 8'h3c;
      rd_chk(16'h1fff, 2);
      for (int i = 0; i < 4; i++) wb[i] = 8'ha0 + 8'(i);
      run(1'b0, 16'h005e, 6'h04);
      check("page nack", {15'h0000, nk}, 16'h0000);
      eb[0] = 8'ha2;
      eb[1] = 8'ha3;
      rd_chk(16'h0040, 2);
      eb[0] = 8'ha0;
      eb[1] = 8'ha1;
      eb[2] = 8'hff;
      rd_chk(16'h005e, 3);
      wprot <= 1'b1;
      wb[0] = 8'h55;
      run(1'b0, 16'h0200, 6'h01);
      check("protect nack", {15'h0000, nk}, 16'h0001);
      check("protect busy", {15'h0000, bz}, 16'h0000);
      wprot <= 1'b0;
      eb[0] = 8'hff;
      rd_chk(16'h0200, 1);
      // Foreign chip code: master polls unanswered, then a reset ends it
      ack_seen = 1'b0;
      issue(1'b1, 3'b101, 16'h0000, 6'h01);
      repeat (3000) @(posedge clk_in);
      check("foreign select ack", {15'h0000, ack_seen}, 16'h0000);
      nrst_in <= 1'b0;
      repeat (16) @(posedge clk_in);
      nrst_in <= 1'b1;
      @(posedge clk_in);
      eb[0] = 8'h3c;
      rd_chk(16'h0000, 1);
      conclude();
   end
endmodule
